// *** bsng_pkg.sv ***
// types shared by the bank and its status tracker
// assumes: constants come from bsng_reg_map.svh
package bsng_pkg;
  typedef struct packed {
    logic [2:0] gate_entry_timer;
    logic [1:0] gate_threshold;
    logic       gate_enable;
    logic       gate_ramp_disable;
    logic [3:0] supply_switch_hysteresis;
    logic       low_signal_threshold_mode;
    logic [4:0] low_signal_threshold;
    logic [1:0] low_signal_threshold_low;
    logic [1:0] active_threshold_code;
  } bsng_cfg_t;
  typedef struct packed {
    logic [4:0] pin_pulldown;
    logic [1:0] serial_data_drive;
    logic [1:0] serial_out_drive;
    logic [1:0] interchip_drive;
  } bsng_pad_t;
  typedef struct packed {
    logic       valid;
    logic [9:0] min_supply_sample;
    logic [2:0] level;
  } bsng_sample_t;
endpackage

// *** bsng_reg_bank.sv ***
// avalon-mm register bank: brownout status, noise gate, signalling, pads
// assumes: single clock, synchronous reset, word addressed 8-bit registers
`timescale 1ns/1ps
`include "bsng_reg_map.svh"
module bsng_reg_bank (
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_in,
  input  wire logic [7:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic [1:0]                  avs_response_out,
  input  wire logic                   converter_enable_in,
  input  wire logic [1:0]             switching_mode_in,
  input  wire bsng_pkg::bsng_sample_t sample_in,
  output bsng_pkg::bsng_cfg_t         cfg_out,
  output bsng_pkg::bsng_pad_t         pad_out,
  output logic                        status_hold_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  low_q;
  logic [7:0]  ng_q;
  logic [7:0]  ramp_q;
  logic [7:0]  sig_q;
  logic [7:0]  pd_q;
  logic [7:0]  drv_q;
  logic        hold_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [1:0]  resp_q;
  logic [9:0]  min_w;
  logic [2:0]  lvl_w;

  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle per access, answered on second cycle
  wire req_w   = (avs_read_in | avs_write_in) & ~ack_q;
  wire wen_w   = avs_write_in & ~ack_q & avs_byteenable_in[0];
  wire [7:0] wd_w = avs_writedata_in[7:0];
  wire hit_hi  = (avs_address_in == `BSNG_OFS_MIN_HIGH);
  wire hit_lo  = (avs_address_in == `BSNG_OFS_MIN_LOW);
  wire hit_ng  = (avs_address_in == `BSNG_OFS_NG_CFG);
  wire hit_rp  = (avs_address_in == `BSNG_OFS_NG_RAMP);
  wire hit_lv  = (avs_address_in == `BSNG_OFS_SIG_CFG);
  wire hit_pd  = (avs_address_in == `BSNG_OFS_PULLDOWN);
  wire hit_dr  = (avs_address_in == `BSNG_OFS_DRIVE);
  wire hit_hd  = (avs_address_in == `BSNG_OFS_HOLD);
  wire mapped_w = hit_hi | hit_lo | hit_ng | hit_rp | hit_lv | hit_pd | hit_dr | hit_hd;

  wire [7:0] rd_w;
  assign rd_w = hit_hi ? min_w[9:2] :
                hit_lo ? {min_w[1:0], lvl_w, low_q[2:0]} :
                hit_ng ? ng_q :
                hit_rp ? ramp_q :
                hit_lv ? sig_q :
                hit_pd ? pd_q :
                hit_dr ? drv_q :
                hit_hd ? {7'h00, hold_q} : 8'h00;

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out    = rdata_q;
  assign avs_response_out    = resp_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= 2'h0;
    end else begin
      ack_q   <= req_w;
      rdata_q <= (req_w & avs_read_in) ? {24'h000000, rd_w} : 32'h0000_0000;
      resp_q  <= (req_w & ~mapped_w) ? 2'h2 : 2'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      low_q  <= `BSNG_RST_MIN_LOW;
      ng_q   <= `BSNG_RST_NG_CFG;
      ramp_q <= `BSNG_RST_NG_RAMP;
      sig_q  <= `BSNG_RST_SIG_CFG;
      pd_q   <= `BSNG_RST_PULLDOWN;
      drv_q  <= `BSNG_RST_DRIVE;
      hold_q <= 1'b0;
    end else if (wen_w) begin
      if (hit_lo) begin
        low_q <= merge(low_q, wd_w, `BSNG_WMASK_MIN_LOW);
      end else if (hit_ng) begin
        ng_q <= merge(ng_q, wd_w, `BSNG_WMASK_NG_CFG);
      end else if (hit_rp) begin
        ramp_q <= merge(ramp_q, wd_w, `BSNG_WMASK_NG_RAMP);
      end else if (hit_lv) begin
        sig_q <= merge(sig_q, wd_w, `BSNG_WMASK_SIG_CFG);
      end else if (hit_pd) begin
        pd_q <= merge(pd_q, wd_w, `BSNG_WMASK_PULLDOWN);
      end else if (hit_dr) begin
        drv_q <= merge(drv_q, wd_w, `BSNG_WMASK_DRIVE);
      end else if (hit_hd) begin
        hold_q <= wd_w[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold freezes status; converter_enable_in low still forces minimum supply to all ones
  bsng_status_track u_track (
    .core_clk_in               (core_clk_in),
    .reset_in                  (reset_in),
    .status_hold_in            (hold_q),
    .converter_enable_in       (converter_enable_in),
    .sample_in                 (sample_in),
    .min_supply_sample_out     (min_w),
    .lowest_level_attacked_out (lvl_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // gate, hysteresis, signalling and pad fields
  assign cfg_out.gate_entry_timer          = ng_q[7:5];
  assign cfg_out.gate_threshold            = ng_q[4:3];
  assign cfg_out.gate_enable               = ng_q[2];
  assign cfg_out.gate_ramp_disable         = ramp_q[5];
  assign cfg_out.supply_switch_hysteresis  = ramp_q[3:0];
  assign cfg_out.low_signal_threshold_mode = sig_q[7];
  assign cfg_out.low_signal_threshold      = sig_q[4:0];
  assign cfg_out.low_signal_threshold_low  = low_q[2:1];
  assign cfg_out.active_threshold_code =
    (switching_mode_in == `BSNG_MODE_LOW)   ? low_q[2:1] :
    (switching_mode_in == `BSNG_MODE_FIXED) ? sig_q[1:0] : 2'h0;
  assign pad_out.pin_pulldown      = pd_q[6:2];
  assign pad_out.serial_data_drive = drv_q[7:6];
  assign pad_out.serial_out_drive  = drv_q[3:2];
  assign pad_out.interchip_drive   = drv_q[1:0];
  assign status_hold_out           = hold_q;
endmodule

// *** bsng_reg_bank_sva.sv ***
// checker: port assertions for the brownout, gate and pad register bank
// assumes: one clock, sync reset, bound to bsng_reg_bank
`timescale 1ns/1ps
module bsng_reg_bank_sva (
  input wire logic                core_clk_in,
  input wire logic                reset_in,
  input wire logic [7:0]          avs_address_in,
  input wire logic                avs_read_in,
  input wire logic                avs_write_in,
  input wire logic [31:0]         avs_writedata_in,
  input wire logic [3:0]          avs_byteenable_in,
  input wire logic [31:0]         avs_readdata_out,
  input wire logic                avs_waitrequest_out,
  input wire logic [1:0]          avs_response_out,
  input wire logic                converter_enable_in,
  input wire logic [1:0]          switching_mode_in,
  input wire bsng_pkg::bsng_cfg_t cfg_out,
  input wire bsng_pkg::bsng_pad_t pad_out,
  input wire logic                status_hold_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire rd_done = avs_read_in && !avs_waitrequest_out;
  wire wr_done = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire unmapped = !(avs_address_in inside {[8'h33:8'h39], 8'h3F});
  ////////////////////////////////////////////////////////////////
  property p_wait; $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("read not answered after one wait cycle");
  property p_unmap; rd_done && unmapped |-> avs_response_out == 2'h2 && avs_readdata_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_ones;
    rd_done && avs_address_in == 8'h33 && !converter_enable_in && !$past(converter_enable_in)
      && !$past(converter_enable_in, 2)
      |-> avs_readdata_out == 32'h0000_00FF;
  endproperty
  a_ones: assert property (p_ones) else $error("minimum supply not all ones");
  property p_rst;
    $fell(reset_in) |-> cfg_out.gate_enable && cfg_out.gate_ramp_disable
      && cfg_out.low_signal_threshold_mode && cfg_out.gate_entry_timer == 3'h5;
  endproperty
  a_rst: assert property (p_rst) else $error("config reset value wrong");
  property p_pad; $fell(reset_in) |-> pad_out == 11'h03F; endproperty
  a_pad: assert property (p_pad) else $error("pad reset value wrong");
  property p_low; switching_mode_in == 2'h3 |-> cfg_out.active_threshold_code == cfg_out.low_signal_threshold_low; endproperty
  a_low: assert property (p_low) else $error("low threshold not selected");
  property p_fix; switching_mode_in == 2'h0 |-> cfg_out.active_threshold_code == cfg_out.low_signal_threshold[1:0]; endproperty
  a_fix: assert property (p_fix) else $error("fixed threshold not selected");
  property p_pd; wr_done && avs_address_in == 8'h38 |=> pad_out.pin_pulldown == $past(avs_writedata_in[6:2]); endproperty
  a_pd: assert property (p_pd) else $error("pull-down write lost");
  property p_drv;
    wr_done && avs_address_in == 8'h39 |=> {pad_out.serial_data_drive, pad_out.serial_out_drive,
      pad_out.interchip_drive} == {$past(avs_writedata_in[7:6]), $past(avs_writedata_in[3:0])};
  endproperty
  a_drv: assert property (p_drv) else $error("drive write lost");
  property p_hold; wr_done && avs_address_in == 8'h3F |=> status_hold_out == $past(avs_writedata_in[0]); endproperty
  a_hold: assert property (p_hold) else $error("status hold write lost");
  c_rd: cover property (rd_done && !unmapped);
  c_wr: cover property (wr_done);
  c_un: cover property (rd_done && unmapped);
endmodule
bind bsng_reg_bank bsng_reg_bank_sva u_sva (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out), .converter_enable_in(converter_enable_in),
  .switching_mode_in(switching_mode_in), .cfg_out(cfg_out), .pad_out(pad_out),
  .status_hold_out(status_hold_out));

// *** bsng_reg_map.svh ***
// register offsets, field positions and reset values for the brownout status,
// noise gate, low-voltage signalling and pad configuration bank
// assumes: 32-bit avalon-mm word addressing, one 8-bit register per word
// Function
// - lowest supply sample since status hold was last cleared, 10 bits: high byte 0x33, low two bits 0x34[7:6]
// - minimum supply fields read all ones until the sampling converter is enabled
// - all-ones default means 16 V main supply or 6 V battery supply
// - lowest attacked brownout level, 3 bits, code 4 means none, resets to 4
// - 2-bit low signalling threshold used when switching mode is 2'b11
// - 3-bit noise gate entry hysteresis timer, resets to 5
// - 2-bit noise gate threshold and gate enable bit, enable set at reset
// - ramp-disable bit: zero ramps volume on gate transitions, resets to one
// - 4-bit main-to-battery hysteresis time, codes 0 to 9 reserved
// - threshold mode bit: zero fixed, one relative to battery, resets to one
// - 5-bit low signalling threshold, its bits 1:0 used when switching mode is 2'b00
// - weak pull-down enables for five pins in bits 6 to 2, reset zero
// - 2-bit drive strength fields for three pins, reset to 11
// - clearing status hold resets held status fields and resumes updating
`ifndef BSNG_REG_MAP_SVH
`define BSNG_REG_MAP_SVH
`define BSNG_OFS_MIN_HIGH   8'h33
`define BSNG_OFS_MIN_LOW    8'h34
`define BSNG_OFS_NG_CFG     8'h35
`define BSNG_OFS_NG_RAMP    8'h36
`define BSNG_OFS_SIG_CFG    8'h37
`define BSNG_OFS_PULLDOWN   8'h38
`define BSNG_OFS_DRIVE      8'h39
`define BSNG_OFS_HOLD       8'h3F
`define BSNG_RST_MIN_HIGH   8'hFF
`define BSNG_RST_MIN_LOW    8'hE6
`define BSNG_RST_NG_CFG     8'hBD
`define BSNG_RST_NG_RAMP    8'hAD
`define BSNG_RST_SIG_CFG    8'hA8
`define BSNG_RST_PULLDOWN   8'h03
`define BSNG_RST_DRIVE      8'hFF
`define BSNG_SAMPLE_ONES    10'h3FF
`define BSNG_LEVEL_NONE     3'h4
`define BSNG_MODE_LOW       2'h3
`define BSNG_MODE_FIXED     2'h0
`define BSNG_WMASK_MIN_LOW  8'h06
`define BSNG_WMASK_NG_CFG   8'hFC
`define BSNG_WMASK_NG_RAMP  8'h2F
`define BSNG_WMASK_SIG_CFG  8'h9F
`define BSNG_WMASK_PULLDOWN 8'h7C
`define BSNG_WMASK_DRIVE    8'hCF
`define BSNG_WMASK_HOLD     8'h01
`endif

// *** bsng_status_track.sv ***
// tracks lowest supply sample and lowest attacked brownout level
// assumes: sample strobes come from logic on core_clk_in
`timescale 1ns/1ps
`include "bsng_reg_map.svh"
module bsng_status_track (
  input  wire logic                  core_clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  status_hold_in,
  input  wire logic                  converter_enable_in,
  input  wire bsng_pkg::bsng_sample_t sample_in,
  output logic [9:0]                 min_supply_sample_out,
  output logic [2:0]                 lowest_level_attacked_out
);
  logic [9:0] min_q;
  logic [9:0] min_d;
  logic [2:0] lvl_q;
  logic [2:0] lvl_d;
  logic       hold_q;
  wire        release_w = hold_q & ~status_hold_in;
  wire        lower_w   = sample_in.valid & (sample_in.min_supply_sample < min_q);
  wire        deeper_w  = sample_in.valid & (sample_in.level < lvl_q);

  assign min_d = (release_w | ~converter_enable_in) ? `BSNG_SAMPLE_ONES :
                 (status_hold_in | ~lower_w) ? min_q : sample_in.min_supply_sample;
  assign lvl_d = release_w ? `BSNG_LEVEL_NONE :
                 (status_hold_in | ~deeper_w) ? lvl_q : sample_in.level;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      min_q  <= `BSNG_SAMPLE_ONES;
      lvl_q  <= `BSNG_LEVEL_NONE;
      hold_q <= 1'b0;
    end else begin
      min_q  <= min_d;
      lvl_q  <= lvl_d;
      hold_q <= status_hold_in;
    end
  end

  assign min_supply_sample_out     = min_q;
  assign lowest_level_attacked_out = lvl_q;
endmodule

// *** tb_top.sv ***
// testbench: register bank driven over avalon-mm
// assumes: design files and checker compiled first
`timescale 1ns/1ps
module tb_top;
  logic                   core_clk_in;
  logic                   reset_in;
  logic [7:0]             avs_address_in;
  logic                   avs_read_in;
  logic                   avs_write_in;
  logic [31:0]            avs_writedata_in;
  logic [31:0]            avs_readdata_out;
  logic                   avs_waitrequest_out;
  logic [1:0]             avs_response_out;
  logic                   converter_enable_in;
  logic [1:0]             switching_mode_in;
  bsng_pkg::bsng_sample_t sample_in;
  bsng_pkg::bsng_cfg_t    cfg_out;
  bsng_pkg::bsng_pad_t    pad_out;
  logic                   status_hold_out;
  logic [31:0]            q;
  logic [1:0]             rsp;
  int                     err_count = 0;
  int                     n_compared = 0;
  bsng_reg_bank uut (.core_clk_in(core_clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_response_out(avs_response_out), .converter_enable_in(converter_enable_in),
    .switching_mode_in(switching_mode_in), .sample_in(sample_in), .cfg_out(cfg_out), .pad_out(pad_out),
    .status_hold_out(status_hold_out));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge core_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    rsp = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic send(input logic [9:0] v, input logic [2:0] l);
    sample_in <= {1'b1, v, l};
    @(posedge core_clk_in);
    sample_in <= {1'b0, v, l};
    @(posedge core_clk_in);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] rv [7] = '{8'hFF, 8'hE6, 8'hBD, 8'hAD, 8'hA8, 8'h03, 8'hFF};
    for (int i = 0; i < 7; i++)
      rdc(8'h33 + i[7:0], rv[i]);
    rdc(8'h3F, 8'h00);
    rdc(8'h50, 8'h00);
    chk({30'h0, rsp}, 32'h2);
  endtask
  task automatic t_rw();
    logic [7:0] lo [7] = '{8'hFF, 8'hE0, 8'h01, 8'h80, 8'h20, 8'h03, 8'h30};
    logic [7:0] hi [7] = '{8'hFF, 8'hE6, 8'hFD, 8'hAF, 8'hBF, 8'h7F, 8'hFF};
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, 8'h33 + i[7:0], 8'h00);
      rdc(8'h33 + i[7:0], lo[i]);
      bus(1'b1, 8'h33 + i[7:0], 8'hFF);
      rdc(8'h33 + i[7:0], hi[i]);
    end
    chk({21'h0, pad_out}, 32'h7FF);
  endtask
  task automatic t_mode();
    logic [1:0] ex [4] = '{2'h2, 2'h0, 2'h0, 2'h1};
    bus(1'b1, 8'h34, 8'h02);
    bus(1'b1, 8'h37, 8'h06);
    for (int m = 0; m < 4; m++) begin
      switching_mode_in <= m[1:0];
      @(posedge core_clk_in);
      @(posedge core_clk_in);
      chk({30'h0, cfg_out.active_threshold_code}, {30'h0, ex[m]});
    end
  endtask
  task automatic t_track();
    converter_enable_in <= 1'b1;
    send(10'h200, 3'h2);
    send(10'h300, 3'h3);
    send(10'h155, 3'h1);
    bus(1'b1, 8'h3F, 8'h01);
    rdc(8'h33, 8'h55);
    rdc(8'h34, 8'h4A);
    send(10'h010, 3'h0);
    rdc(8'h33, 8'h55);
    bus(1'b1, 8'h3F, 8'h00);
    send(10'h2FD, 3'h2);
    bus(1'b1, 8'h3F, 8'h01);
    rdc(8'h33, 8'hBF);
    rdc(8'h34, 8'h52);
    converter_enable_in <= 1'b0;
    @(posedge core_clk_in);
    rdc(8'h33, 8'hFF);
    bus(1'b1, 8'h3F, 8'h00);
    bus(1'b1, 8'h3F, 8'h01);
    rdc(8'h34, 8'hE2);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_count++;
    results();
  end
  initial begin
    reset_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    converter_enable_in = 1'b0;
    switching_mode_in = 2'h1;
    sample_in = '0;
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    t_reset();
    t_rw();
    t_mode();
    t_track();
    results();
  end
endmodule
